// file: test/pitc_chk.sv
/* Port assertions of the interrupt and transfer controller.
   Assumes binding to pitc_top; base parameters are handed on. */
`timescale 1ns/1ps
module pitc_chk #(
  parameter logic [23:0] VEC_BASE  = 24'h000000,
  parameter logic [6:0]  TRAP_BASE = 7'h00
) (
  input wire logic                 i_core_clk,        // Clock
  input wire logic                 i_rst_b,           // Reset
  input wire logic                 i_avs_read,        // Read strobe
  input wire logic                 i_avs_write,       // Write strobe
  input wire logic                 o_avs_waitrequest, // Stall
  input wire logic [3:0]           i_cpu_lvl,         // Core level
  input wire logic                 i_trap_valid,      // Trap pulse
  input wire logic                 o_int_valid,       // Int offer
  input wire pitc_pkg::pitc_int_t  o_int,             // Int data
  input wire logic                 i_int_ack,         // Int taken
  input wire logic                 o_xfer_valid,      // Move offer
  input wire pitc_pkg::pitc_xfer_t o_xfer,            // Move data
  input wire logic                 i_xfer_ack         // Move done
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  // Offer steps
  sequence s_int_taken; o_int_valid && i_int_ack; endsequence
  sequence s_xfer_taken; o_xfer_valid && i_xfer_ack; endsequence
  sequence s_one_wait; o_avs_waitrequest ##1 !o_avs_waitrequest; endsequence
  property p_int_hold; o_int_valid && !i_int_ack |=> o_int_valid && $stable(o_int); endproperty
  a_int_hold: assert property (p_int_hold) else $error("int offer moved early");
  property p_int_drop; s_int_taken |=> !o_int_valid && !o_xfer_valid; endproperty
  a_int_drop: assert property (p_int_drop) else $error("offer after int ack");
  property p_xfer_hold; o_xfer_valid && !i_xfer_ack |=> o_xfer_valid && $stable(o_xfer); endproperty
  a_xfer_hold: assert property (p_xfer_hold) else $error("move offer moved early");
  property p_xfer_one; s_xfer_taken |=> !o_xfer_valid; endproperty
  a_xfer_one: assert property (p_xfer_one) else $error("move held past one cycle");
  property p_excl; !(o_int_valid && o_xfer_valid); endproperty
  a_excl: assert property (p_excl) else $error("int and move offered together");
  property p_trap_resp; i_trap_valid && !o_int_valid && !o_xfer_valid |-> ##[1:12] o_int_valid; endproperty
  a_trap_resp: assert property (p_trap_resp) else $error("trap not served in time");
  property p_vec; $rose(o_int_valid) |-> o_int.vec == (o_int.sw ? 24'(o_int.num) * 4 :
    VEC_BASE + 24'(o_int.num - TRAP_BASE) * 4); endproperty
  a_vec: assert property (p_vec) else $error("wrong vector");
  property p_lvl; $rose(o_int_valid) && !o_int.sw |-> o_int.lvl > $past(i_cpu_lvl); endproperty
  a_lvl: assert property (p_lvl) else $error("level not above core");
  property p_sw_lvl; $rose(o_int_valid) && o_int.sw |-> o_int.lvl == $past(i_cpu_lvl); endproperty
  a_sw_lvl: assert property (p_sw_lvl) else $error("trap level wrong");
  property p_wait; $rose(i_avs_read || i_avs_write) |-> s_one_wait; endproperty
  a_wait: assert property (p_wait) else $error("bus wait not one cycle");
endmodule : pitc_chk
bind pitc_top pitc_chk #(.VEC_BASE(VEC_BASE), .TRAP_BASE(TRAP_BASE)) i_chk (
  .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest), .i_cpu_lvl(i_cpu_lvl),
  .i_trap_valid(i_trap_valid), .o_int_valid(o_int_valid), .o_int(o_int),
  .i_int_ack(i_int_ack), .o_xfer_valid(o_xfer_valid), .o_xfer(o_xfer),
  .i_xfer_ack(i_xfer_ack));

// file: test/pitc_core_model.sv
/* Core model: takes offered ints and moves after a delay.
   Assumes offers hold until acknowledged. */
`timescale 1ns/1ps
module pitc_core_model (
  input  wire logic                 i_core_clk,   // Clock
  input  wire logic                 i_rst_b,      // Reset
  input  wire logic [3:0]           i_dly,        // Ack delay
  input  wire logic                 i_int_valid,  // Int offer
  input  wire pitc_pkg::pitc_int_t  i_int,        // Int data
  input  wire logic                 i_xfer_valid, // Move offer
  input  wire pitc_pkg::pitc_xfer_t i_xfer,       // Move data
  output logic                      o_int_ack,    // Int taken
  output logic                      o_xfer_ack,   // Move done
  output pitc_pkg::pitc_int_t       o_last_int,   // Last int
  output pitc_pkg::pitc_xfer_t      o_last_xfer,  // Last move
  output int                        o_n_int,      // Ints taken
  output int                        o_n_xfer      // Moves done
);
  logic [3:0] wait_cnt;
  // Ack pulse after the delay, log what was taken
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      {o_int_ack, o_xfer_ack, wait_cnt} <= '0;
      {o_last_int, o_last_xfer, o_n_int, o_n_xfer} <= '0;
    end else begin
      o_int_ack <= 1'b0;
      o_xfer_ack <= 1'b0;
      if (i_int_valid && o_int_ack) begin
        o_last_int <= i_int;
        o_n_int <= o_n_int + 1;
      end
      if (i_xfer_valid && o_xfer_ack) begin
        o_last_xfer <= i_xfer;
        o_n_xfer <= o_n_xfer + 1;
      end
      wait_cnt <= 4'h0;
      if ((i_int_valid || i_xfer_valid) && !o_int_ack && !o_xfer_ack) begin
        wait_cnt <= wait_cnt + 4'h1;
        if (wait_cnt >= i_dly) begin
          o_int_ack <= i_int_valid;
          o_xfer_ack <= i_xfer_valid;
          wait_cnt <= 4'h0;
        end
      end
    end
  end
endmodule : pitc_core_model

// file: test/pitc_tb_top.sv
/* Self-checking bench of the interrupt and transfer controller.
   Assumes the bound checker and the core model beside the design. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module pitc_tb_top;
  logic clk = 1'b0, rst_b = 1'b0, rd_s = 1'b0, wr_s = 1'b0, trap_v = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic [15:0] src_req = 16'h0;
  logic [7:0]  pin = 8'h0;
  logic [6:0]  trap_n = 7'h00;
  logic [3:0]  cpu_lvl = 4'h0, dly = 4'h0;
  logic        wait_r, int_v, int_a, xfer_v, xfer_a, irq;
  pitc_pkg::pitc_int_t  int_d, last_int;
  pitc_pkg::pitc_xfer_t xfer_d, last_xfer;
  int n_int, n_xfer, cyc = 0, err_count = 0, num_checks = 0;
  pitc_top i_dut (.i_core_clk(clk), .i_rst_b(rst_b), .i_avs_address(addr),
    .i_avs_read(rd_s), .i_avs_write(wr_s), .i_avs_writedata(wdata),
    .i_avs_byteenable(4'hf), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_r),
    .i_src_req(src_req), .i_ext_pin(pin), .i_cpu_lvl(cpu_lvl), .i_trap_valid(trap_v),
    .i_trap_num(trap_n), .o_int_valid(int_v), .o_int(int_d), .i_int_ack(int_a),
    .o_xfer_valid(xfer_v), .o_xfer(xfer_d), .i_xfer_ack(xfer_a), .o_irq(irq));
  pitc_core_model i_core (.i_core_clk(clk), .i_rst_b(rst_b), .i_dly(dly),
    .i_int_valid(int_v), .i_int(int_d), .i_xfer_valid(xfer_v), .i_xfer(xfer_d),
    .o_int_ack(int_a), .o_xfer_ack(xfer_a), .o_last_int(last_int),
    .o_last_xfer(last_xfer), .o_n_int(n_int), .o_n_xfer(n_xfer));
  // 40 MHz clock
  always #12.5 clk = ~clk;
  // Verdict and end of run
  task automatic wrap_up;
    if (err_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      wrap_up();
    end
  end
  // One bus access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    logic s;
    addr <= a;
    wdata <= d;
    wr_s <= w;
    rd_s <= !w;
    do begin
      @(posedge clk);
      s = wait_r;
      q = rdata;
    end while (s);
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK("readdata", e, q)
  endtask : rd
  // Pulse sources, then wait for a taken int or move
  task automatic pulse(input logic [15:0] m);
    src_req <= m;
    @(posedge clk);
    src_req <= 16'h0;
  endtask : pulse
  task automatic take(input logic xf, input logic [23:0] v, input logic [3:0] l);
    int n0;
    n0 = xf ? n_xfer : n_int;
    while ((xf ? n_xfer : n_int) == n0) begin
      @(posedge clk);
    end
    if (xf) `CHK("move src", v, last_xfer.src)
    else `CHK("int vec", v, last_int.vec)
    if (!xf) `CHK("int lvl", l, last_int.lvl)
  endtask : take
  task automatic none;
    int n0;
    n0 = n_int;
    repeat (20) @(posedge clk);
    `CHK("int count", n0, n_int)
  endtask : none
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(12'h00c, 32'h0);
    wr(12'h00c, 32'h75);
    rd(12'h00c, 32'h45);
    rd(12'h300, 32'h0);
    pulse(16'h0008);
    take(1'b0, 24'h00000c, 4'h5);
    rd(12'h00c, 32'h45);
    dly <= 4'h5;
    wr(12'h004, 32'h47);
    wr(12'h010, 32'h47);
    wr(12'h014, 32'h49);
    pulse(16'h0032);
    take(1'b0, 24'h000014, 4'h9);
    take(1'b0, 24'h000004, 4'h7);
    take(1'b0, 24'h000010, 4'h7);
    dly <= 4'h0;
    cpu_lvl <= 4'h9;
    pulse(16'h0020);
    none();
    cpu_lvl <= 4'h8;
    take(1'b0, 24'h000014, 4'h9);
    cpu_lvl <= 4'h0;
    wr(12'h018, 32'hc2);
    take(1'b0, 24'h000018, 4'h2);
    trap_n <= 7'h2a;
    trap_v <= 1'b1;
    @(posedge clk);
    trap_v <= 1'b0;
    take(1'b0, 24'h0000a8, 4'h0);
    `CHK("trap flag", 1'b1, last_int.sw)
    `CHK("trap num", 7'h2a, last_int.num)
    wr(12'h000, 32'h43);
    wr(12'h208, 32'h1);
    pin <= 8'h01;
    take(1'b0, 24'h000000, 4'h3);
    pin <= 8'h00;
    none();
    wr(12'h208, 32'h2);
    pin <= 8'h01;
    none();
    pin <= 8'h00;
    take(1'b0, 24'h000000, 4'h3);
    wr(12'h120, 32'h1000);
    wr(12'h124, 32'h2000);
    wr(12'h128, 32'h2);
    wr(12'h12c, 32'h5);
    wr(12'h01c, 32'h544);
    wr(12'h204, 32'h4);
    pulse(16'h0080);
    take(1'b1, 24'h001000, 4'h0);
    `CHK("move dst", 24'h002000, last_xfer.dst)
    `CHK("move word", 1'b1, last_xfer.word)
    `CHK("move chan", 3'h2, last_xfer.chan)
    rd(12'h120, 32'h1002);
    rd(12'h128, 32'h1);
    pulse(16'h0080);
    take(1'b1, 24'h001002, 4'h0);
    take(1'b0, 24'h00001c, 4'h4);
    rd(12'h200, 32'h4);
    `CHK("irq on", 1'b1, irq)
    wr(12'h200, 32'h4);
    `CHK("irq off", 1'b0, irq)
    wr(12'h138, 32'h1);
    wr(12'h13c, 32'ha);
    wr(12'h018, 32'h742);
    pulse(16'h0040);
    take(1'b1, 24'h000000, 4'h0);
    `CHK("byte move", 1'b0, last_xfer.word)
    rd(12'h134, 32'h1);
    rd(12'h138, 32'h1);
    wrap_up();
  end
endmodule : pitc_tb_top

// file: verilog/pitc_cfg.svh
/*
 * Offsets, field positions, reset values and widths of the
 * prioritised interrupt and transfer controller.
 * Assumes inclusion from the package and the module only.
 */
`ifndef PITC_CFG_SVH
`define PITC_CFG_SVH

// Widths
`define PITC_ADDR_W   24
`define PITC_CNT_W    8
`define PITC_LVL_W    4
`define PITC_NUM_W    7
`define PITC_CTL_W    12

// Register byte offsets
`define PITC_OFS_CTRL 12'h000
`define PITC_OFS_CHAN 12'h100
`define PITC_OFS_STAT 12'h200
`define PITC_OFS_MASK 12'h204
`define PITC_OFS_EDGE 12'h208

// Source control fields
`define PITC_F_LVL    3:0
`define PITC_F_EN     6
`define PITC_F_REQ    7
`define PITC_F_XFR    8
`define PITC_F_CH     11:9

// Channel mode fields
`define PITC_M_WORD   0
`define PITC_M_INC    2:1
`define PITC_M_CONT   3
`define PITC_INC_DST  2'h1
`define PITC_INC_SRC  2'h2

// Edge select codes
`define PITC_EDGE_RISE 0
`define PITC_EDGE_FALL 1

// Reset values
`define PITC_RST_CTRL 12'h000
`define PITC_RST_EDGE 16'h0000

`endif

// file: verilog/pitc_pkg.sv
/*
 * Types of the interrupt and transfer controller.
 * Assumes pitc_cfg.svh is on the include path.
 */
`include "pitc_cfg.svh"
package pitc_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_INT, ST_XFER} pitc_fsm_t;

  // One transfer channel
  typedef struct packed {
    logic [`PITC_ADDR_W-1:0] src;
    logic [`PITC_ADDR_W-1:0] dst;
    logic [`PITC_CNT_W-1:0]  cnt;
    logic [3:0]              mode;
  } pitc_chan_t;

  // Interrupt offered to the core
  typedef struct packed {
    logic [`PITC_ADDR_W-1:0] vec;
    logic [`PITC_LVL_W-1:0]  lvl;
    logic [`PITC_NUM_W-1:0]  num;
    logic                    sw;
  } pitc_int_t;

  // One-cycle move offered to the core
  typedef struct packed {
    logic [`PITC_ADDR_W-1:0] src;
    logic [`PITC_ADDR_W-1:0] dst;
    logic                    word;
    logic [2:0]              chan;
  } pitc_xfer_t;
endpackage : pitc_pkg

// file: verilog/pitc_top.sv
/*
 * Prioritised interrupt controller with eight event transfer
 * channels, fast edge inputs, software traps and an Avalon-MM
 * register slave. Assumes inputs synchronous to i_core_clk and a
 * core that acknowledges each offered interrupt or move.
 * The core must raise i_cpu_lvl while it serves an interrupt:
 * that compare is the only preemption gate. Source requests are
 * one-cycle pulses; fast inputs are sampled every clock.
 */
// Added by the designer: the Avalon-MM register port and the placing of the registers.
// Behaviour
// - start service within 5 to 12 clocks
// - each source: vectored or event transfer
// - transfer steals one core cycle only
// - move exactly one byte or word
// - increment source or destination pointer
// - count down unless continuous mode
// - count zero raises source vector interrupt
// - eight channels, own pointers, count, mode
// - per source request, enable, priority
// - sixteen priority levels
// - preempt only for strictly higher priority
// - distinct vector per source
// - fast inputs detect programmed edges
// - trap number selects software vector
// - software-set flag serviced like hardware
`timescale 1ns/1ps
`include "pitc_cfg.svh"
module pitc_top #(
  parameter int N_SRC = 16,
  parameter int N_EXT = 8,
  parameter int N_CH  = 8,
  // Arbitrary vector and trap bases
  parameter logic [`PITC_ADDR_W-1:0] VEC_BASE  = 24'h000000,
  parameter logic [`PITC_NUM_W-1:0]  TRAP_BASE = 7'h00
) (
  input  wire logic                    i_core_clk,      // Core clock
  input  wire logic                    i_rst_b,         // Async reset
  input  wire logic [11:0]             i_avs_address,   // Byte address
  input  wire logic                    i_avs_read,      // Read strobe
  input  wire logic                    i_avs_write,     // Write strobe
  input  wire logic [31:0]             i_avs_writedata, // Write data
  input  wire logic [3:0]              i_avs_byteenable,// Byte lanes
  output logic      [31:0]             o_avs_readdata,  // Read data
  output logic                         o_avs_waitrequest,// Stall
  input  wire logic [N_SRC-1:0]        i_src_req,       // Source pulses
  input  wire logic [N_EXT-1:0]        i_ext_pin,       // Fast inputs
  input  wire logic [`PITC_LVL_W-1:0]  i_cpu_lvl,       // Core level
  input  wire logic                    i_trap_valid,    // Trap pulse
  input  wire logic [`PITC_NUM_W-1:0]  i_trap_num,      // Trap number
  output logic                         o_int_valid,     // Offer int
  output pitc_pkg::pitc_int_t          o_int,           // Int data
  input  wire logic                    i_int_ack,       // Int taken
  output logic                         o_xfer_valid,    // Offer move
  output pitc_pkg::pitc_xfer_t         o_xfer,          // Move data
  input  wire logic                    i_xfer_ack,      // Move done
  output logic                         o_irq            // Status irq
);
  localparam int SRC_W = (N_SRC > 1) ? $clog2(N_SRC) : 1;
  localparam int CH_W  = (N_CH > 1) ? $clog2(N_CH) : 1;

  // All state in one word, reset to zero: idle, every source and
  // channel cleared, all edges off.
  typedef struct packed {
    pitc_pkg::pitc_fsm_t                    fsm;
    logic [N_SRC-1:0][`PITC_CTL_W-1:0]      ctrl;
    pitc_pkg::pitc_chan_t [N_CH-1:0]        ch;
    logic [N_CH-1:0]                        stat;
    logic [N_CH-1:0]                        mask;
    logic [2*N_EXT-1:0]                     edge_sel;
    logic [N_EXT-1:0]                       ext_q;
    logic                                   trap_pend;
    logic [`PITC_NUM_W-1:0]                 trap_num;
    logic [SRC_W-1:0]                       cur;
    logic                                   cur_sw;
    logic                                   ack;
    logic [31:0]                            rdata;
    pitc_pkg::pitc_int_t                    int_o;
    pitc_pkg::pitc_xfer_t                   xfer_o;
  } pitc_state_t;

  pitc_state_t               s;
  pitc_state_t               next_s;
  logic [N_SRC-1:0]          hw_set;
  logic [N_SRC-1:0]          clr;
  logic [N_CH-1:0]           stat_set;
  logic                      bus_req;
  logic                      wr_go;
  logic [SRC_W-1:0]          best_idx;
  logic [`PITC_LVL_W-1:0]    best_lvl;
  logic                      best_any;
  logic [CH_W-1:0]           win_ch;
  logic [CH_W-1:0]           cur_ch;
  logic [CH_W-1:0]           a_ch;
  logic [SRC_W-1:0]          a_src;
  pitc_pkg::pitc_chan_t      cc;
  logic [`PITC_ADDR_W-1:0]   step;

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    merge = (old & ~m) | (wd & m);
  endfunction : merge

  // Request sources: peripheral pulses plus edge hits on fast inputs
  // The previous pin sample resets low, so a pin idling high shows
  // one false rising edge after reset; edges reset off, so it sets no flag.
  genvar g;
  generate
    for (g = 0; g < N_SRC; g++) begin : g_src
      if (g < N_EXT) begin : g_ext
        logic rise;
        logic fall;
        assign rise = i_ext_pin[g] & ~s.ext_q[g];
        assign fall = ~i_ext_pin[g] & s.ext_q[g];
        assign hw_set[g] = i_src_req[g]
          | (rise & s.edge_sel[2*g+`PITC_EDGE_RISE])
          | (fall & s.edge_sel[2*g+`PITC_EDGE_FALL]);
      end else begin : g_int
        assign hw_set[g] = i_src_req[g];
      end
    end
  endgenerate

  // Arbiter: highest level among pending enabled, lowest index on tie
  // Scanning down and keeping ties lets the lowest index win.
  // Level 0 never beats the core level, so it works as off.
  always_comb begin
    best_idx = '0;
    best_lvl = '0;
    best_any = 1'b0;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (s.ctrl[i][`PITC_F_REQ] && s.ctrl[i][`PITC_F_EN] &&
          (!best_any || s.ctrl[i][`PITC_F_LVL] >= best_lvl)) begin
        best_any = 1'b1;
        best_idx = SRC_W'(i);
        best_lvl = s.ctrl[i][`PITC_F_LVL];
      end
    end
  end

  // Bus handshake: one wait cycle then answer
  // First edge sets ack, ending the wait, and latches read data;
  // second edge clears ack and lands the write. Each access costs two
  // cycles, and a request still high after its answer starts a new one.
  assign bus_req           = i_avs_read | i_avs_write;
  assign wr_go             = i_avs_write & s.ack;
  assign o_avs_waitrequest = bus_req & ~s.ack;
  assign o_avs_readdata    = s.rdata;

  // Decoded indices
  // Pointer step: one for a byte, two for a word
  assign a_src  = SRC_W'(i_avs_address[11:2]);
  assign a_ch   = CH_W'(i_avs_address[7:4]);
  assign win_ch = CH_W'(s.ctrl[best_idx][`PITC_F_CH]);
  assign cur_ch = CH_W'(s.ctrl[s.cur][`PITC_F_CH]);
  assign cc     = s.ch[cur_ch];
  assign step   = cc.mode[`PITC_M_WORD] ? `PITC_ADDR_W'(2) : `PITC_ADDR_W'(1);

  // Core-side outputs
  // Valids are decoded from the state; the offer
  // data behind them comes from flip-flops.
  assign o_int_valid  = (s.fsm == pitc_pkg::ST_INT);
  assign o_xfer_valid = (s.fsm == pitc_pkg::ST_XFER);
  assign o_int        = s.int_o;
  assign o_xfer       = s.xfer_o;
  assign o_irq        = |(s.stat & s.mask);

  // Register map, byte offsets, 32-bit words:
  //   0x000+4*i  source i control
  //     [3:0]    priority level, 15 highest
  //     [5:4]    unused, read as zero
  //     [6]      enable
  //     [7]      request flag, hardware or software
  //     [8]      serve by move instead of vector
  //     [11:9]   transfer channel
  //   0x100+16*c channel c
  //     +0x0     source pointer
  //     +0x4     destination pointer
  //     +0x8     transfer count, 8 bits
  //     +0xc     mode
  //       [0]    word move, else byte move
  //       [2:1]  01 bumps destination, 10 source
  //       [3]    continuous, count left alone
  //   0x200      count-zero status, write one clears
  //   0x204      mask of the same layout, feeds o_irq
  //   0x208      edge select, two bits per fast input
  //     bit 2e   rising edge of input e
  //     bit 2e+1 falling edge of input e
  //   Other offsets read zero and ignore writes.

  // Service timing on the core side:
  //   edge k     a request flag is set
  //   edge k+1   the arbiter picks it, offer registered
  //   cycle k+2  o_int_valid or o_xfer_valid high
  //   ack edge   pointers, count and flag update
  //   An idle cycle follows every ack.
  // A pending trap goes ahead of every source.
  // A spent, non-continuous channel falls back to
  // the vector, so its request is never lost.
  // Channels stay writable during an offered move.
  // Vector = VEC_BASE + 4*index; number =
  // TRAP_BASE + index; a trap uses 4*number.
  // A move steals one core cycle; the program is
  // not suspended and no vector is taken.
  // Preemption comes only from i_cpu_lvl: an offer
  // already made is never replaced.

  // Next-state logic
  always_comb begin
    next_s   = s;
    clr      = '0;
    stat_set = '0;
    next_s.ext_q = i_ext_pin;
    next_s.ack   = bus_req & ~s.ack;

    // Read data, latched in the wait cycle
    // It then holds until the next read, so the
    // master can take it at its answer edge.
    if (!(i_avs_read && !s.ack)) begin
      next_s.rdata = s.rdata;
    end else if (i_avs_address < `PITC_OFS_CTRL + 12'(4 * N_SRC)) begin
      next_s.rdata = 32'(s.ctrl[a_src] & 12'hfcf);
    end else if (i_avs_address >= `PITC_OFS_CHAN &&
                 i_avs_address < `PITC_OFS_CHAN + 12'(16 * N_CH)) begin
      if (i_avs_address[3:2] == 2'h0) begin
        next_s.rdata = 32'(s.ch[a_ch].src);
      end else if (i_avs_address[3:2] == 2'h1) begin
        next_s.rdata = 32'(s.ch[a_ch].dst);
      end else if (i_avs_address[3:2] == 2'h2) begin
        next_s.rdata = 32'(s.ch[a_ch].cnt);
      end else begin
        next_s.rdata = 32'(s.ch[a_ch].mode);
      end
    end else if (i_avs_address == `PITC_OFS_STAT) begin
      next_s.rdata = 32'(s.stat);
    end else if (i_avs_address == `PITC_OFS_MASK) begin
      next_s.rdata = 32'(s.mask);
    end else if (i_avs_address == `PITC_OFS_EDGE) begin
      next_s.rdata = 32'(s.edge_sel);
    end else begin
      next_s.rdata = 32'h0000_0000;
    end

    // Software trap is held until offered
    // A second trap before the offer replaces the number.
    if (i_trap_valid) begin
      next_s.trap_pend = 1'b1;
      next_s.trap_num  = i_trap_num;
    end

    // Service sequencer
    case (s.fsm)
      pitc_pkg::ST_IDLE: begin
        if (s.trap_pend) begin
          next_s.int_o.vec = `PITC_ADDR_W'({s.trap_num, 2'b00});
          next_s.int_o.lvl = i_cpu_lvl;
          next_s.int_o.num = s.trap_num;
          next_s.int_o.sw  = 1'b1;
          next_s.cur_sw    = 1'b1;
          next_s.trap_pend = i_trap_valid;
          next_s.fsm       = pitc_pkg::ST_INT;
        end else if (best_any && best_lvl > i_cpu_lvl) begin
          next_s.cur    = best_idx;
          next_s.cur_sw = 1'b0;
          if (s.ctrl[best_idx][`PITC_F_XFR] &&
              (s.ch[win_ch].cnt != '0 ||
               s.ch[win_ch].mode[`PITC_M_CONT])) begin
            next_s.xfer_o.src  = s.ch[win_ch].src;
            next_s.xfer_o.dst  = s.ch[win_ch].dst;
            next_s.xfer_o.word = s.ch[win_ch].mode[`PITC_M_WORD];
            next_s.xfer_o.chan = 3'(win_ch);
            next_s.fsm         = pitc_pkg::ST_XFER;
          end else begin
            next_s.int_o.vec = VEC_BASE +
              `PITC_ADDR_W'({best_idx, 2'b00});
            next_s.int_o.lvl = best_lvl;
            next_s.int_o.num = TRAP_BASE + `PITC_NUM_W'(best_idx);
            next_s.int_o.sw  = 1'b0;
            next_s.fsm       = pitc_pkg::ST_INT;
          end
        end
      end
      pitc_pkg::ST_INT: begin
        if (i_int_ack) begin
          clr[s.cur] = ~s.cur_sw;
          next_s.fsm = pitc_pkg::ST_IDLE;
        end
      end
      pitc_pkg::ST_XFER: begin
        if (i_xfer_ack) begin
          if (cc.mode[`PITC_M_INC] == `PITC_INC_SRC) begin
            next_s.ch[cur_ch].src = cc.src + step;
          end else if (cc.mode[`PITC_M_INC] == `PITC_INC_DST) begin
            next_s.ch[cur_ch].dst = cc.dst + step;
          end
          if (!cc.mode[`PITC_M_CONT]) begin
            next_s.ch[cur_ch].cnt = cc.cnt - `PITC_CNT_W'(1);
          end
          // Last move keeps the flag so the vector follows
          if (!cc.mode[`PITC_M_CONT] && cc.cnt == `PITC_CNT_W'(1)) begin
            stat_set[cur_ch] = 1'b1;
          end else begin
            clr[s.cur] = 1'b1;
          end
          next_s.fsm = pitc_pkg::ST_IDLE;
        end
      end
      default: begin
        next_s.fsm = pitc_pkg::ST_IDLE;
      end
    endcase

    // Register writes
    if (!wr_go) begin
      next_s.stat = s.stat;
    end else if (i_avs_address < `PITC_OFS_CTRL + 12'(4 * N_SRC)) begin
      next_s.ctrl[a_src] = 12'(merge(32'(s.ctrl[a_src]), i_avs_writedata,
                                     i_avs_byteenable));
    end else if (i_avs_address >= `PITC_OFS_CHAN &&
                 i_avs_address < `PITC_OFS_CHAN + 12'(16 * N_CH)) begin
      if (i_avs_address[3:2] == 2'h0) begin
        next_s.ch[a_ch].src = `PITC_ADDR_W'(merge(32'(s.ch[a_ch].src),
                                i_avs_writedata, i_avs_byteenable));
      end else if (i_avs_address[3:2] == 2'h1) begin
        next_s.ch[a_ch].dst = `PITC_ADDR_W'(merge(32'(s.ch[a_ch].dst),
                                i_avs_writedata, i_avs_byteenable));
      end else if (i_avs_address[3:2] == 2'h2) begin
        next_s.ch[a_ch].cnt = `PITC_CNT_W'(merge(32'(s.ch[a_ch].cnt),
                                i_avs_writedata, i_avs_byteenable));
      end else begin
        next_s.ch[a_ch].mode = 4'(merge(32'(s.ch[a_ch].mode),
                                i_avs_writedata, i_avs_byteenable));
      end
    end else if (i_avs_address == `PITC_OFS_STAT) begin
      next_s.stat = s.stat & ~N_CH'(i_avs_writedata & {{24{1'b0}},
                    {8{i_avs_byteenable[0]}}});
    end else if (i_avs_address == `PITC_OFS_MASK) begin
      next_s.mask = N_CH'(merge(32'(s.mask), i_avs_writedata,
                                i_avs_byteenable));
    end else if (i_avs_address == `PITC_OFS_EDGE) begin
      next_s.edge_sel = (2*N_EXT)'(merge(32'(s.edge_sel), i_avs_writedata,
                                         i_avs_byteenable));
    end

    // Flags: service clears, new hardware events win over any clear
    // A last move and a status write in one cycle
    // leave the status bit set.
    for (int i = 0; i < N_SRC; i++) begin
      if (clr[i]) begin
        next_s.ctrl[i][`PITC_F_REQ] = 1'b0;
      end
      if (hw_set[i]) begin
        next_s.ctrl[i][`PITC_F_REQ] = 1'b1;
      end
      next_s.ctrl[i][5:4] = 2'b00;
    end
    next_s.stat = next_s.stat | stat_set;
  end

  // State register
  // One register for the whole state word
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule : pitc_top
